// ---- src/sync_sel_defs.svh ----
// Offsets, field positions, reset values and timing of the sync selector
`ifndef SYNC_SEL_DEFS_SVH
`define SYNC_SEL_DEFS_SVH

`define CLK_PERIOD_PS 4000
`define MON_SAMPLE_PS 3200
`define SWEEP_PULSE_PS 6400
`define DEAD_TIME_PS 96000
`define CYCLES_CEIL(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define OFF_CTRL 8'h00
`define OFF_EDGE 8'h04
`define OFF_SEL 8'h08
`define OFF_RANGE 8'h0C
`define OFF_HOLDOFF 8'h10
`define OFF_STATUS 8'h14
`define OFF_COUNT0 8'h20
`define OFF_COUNT5 8'h34

`define CTRL_ARM 0
`define CTRL_ACQ 1
`define CTRL_HALT_WATCH 2
`define SEL1_LSB 0
`define INV1_BIT 7
`define SEL2_LSB 8
`define INV2_BIT 15
`define STAT_HALT_BIT 3
`define STAT_SWEEP_LSB 16

`define CTRL_RESET 32'h0000_0000
`define EDGE_RESET 12'h555
`define SEL_RESET 16'h0000
`define RANGE_RESET 32'h0000_00FF
`define HOLDOFF_RESET 32'h0000_0000

`define SRC_COUNT 64
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- src/sync_sel_pkg.sv ----
// Types shared by the sync output selector files
package sync_sel_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_WINDOW,
        ST_DEAD,
        ST_HOLDOFF
    } sweep_state_t;
    typedef logic [6:0] src_sel_t;
    typedef logic [1:0] edge_mode_t;
endpackage : sync_sel_pkg

// ---- src/sync_source_mux.sv ----
// One sync output: source pick, optional inversion, registered pin levels
`timescale 1ns/1ps
`include "sync_sel_defs.svh"
module sync_source_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`SRC_COUNT-1:0] src,
    input wire sync_sel_pkg::src_sel_t sel,
    input wire logic invert,
    output logic nim_level_n_reg,
    output logic ttl_level_reg
);
    import sync_sel_pkg::*;

    function automatic logic pick(input logic [`SRC_COUNT-1:0] v,
                                  input src_sel_t s);
        logic r;
        r = 1'b0;
        if (s < 7'(`SRC_COUNT)) begin
            r = v[s[5:0]];
        end
        return r;
    endfunction : pick

    wire logic picked = pick(src, sel);     // [R18]
    wire logic level = picked ^ invert;     // [R14]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nim_level_n_reg <= 1'b1;
            ttl_level_reg <= 1'b0;
        end else begin
            nim_level_n_reg <= ~level;      // [R15]
            ttl_level_reg <= level;         // [R14]
        end
    end
endmodule : sync_source_mux

// ---- src/sync_output_selector.sv ----
// Sync output selector: sweep engine, monitors, registers over AXI4-Lite
// What this block does
// R01: Each trigger and event input counts rising, falling or both edges.
// R02: Each channel counts bursts of edges independently without losing any.
// R03: Acquisition counts every edge that reaches the input stage.
// R04: Discriminated inputs are sampled every cycle for the monitor sources.
// R05: A routed monitor pulse lasts at least one sample period.
// R06: Sources include zero, 10 MHz reference, 100 MHz and 200 MHz clocks.
// R07: Sources include sampling clock divided by 128, 64 and 32.
// R08: Six monitor sources, trigger input and five event inputs.
// R09: Status sources: halt line, armed, acquisition on, window, hold-off, dead.
// R10: Sweep-begin source emits one pulse per new sweep, 6.4 ns rounded up to two 4 ns cycles (8 ns).
// R11: Timer taps 0 to 31, tap n period 2^(n+1) ticks, only while sampling.
// R12: Sweep counter bits 0 to 11 are each selectable.
// R13: Sweep counter increments once per started sweep.
// R14: Both outputs take any source with independent inversion.
// R15: Fast output drives true as low level unless inverted.
// R16: Armed device starts a sweep on a trigger edge.
// R17: Window end is followed by 96 ns dead time before re-arm.
// R18: Software selection field per output; unused codes give zero.
`timescale 1ns/1ps
`include "sync_sel_defs.svh"
module sync_output_selector (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] disc_in,
    input wire logic halt_line_in,
    input wire logic ref_10m_in,
    input wire logic clk_100m_in,
    input wire logic clk_200m_in,
    input wire logic div128_in,
    input wire logic div64_in,
    input wire logic div32_in,
    output logic fast_sync_n,
    output logic ttl_sync
);
    import sync_sel_pkg::*;

    localparam logic [1:0] BEGIN_CYC = 2'(`CYCLES_CEIL(`SWEEP_PULSE_PS));
    localparam logic [31:0] DEAD_CYC = 32'(`CYCLES_CEIL(`DEAD_TIME_PS));

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; pin clocks alias when sampled at 250 MHz
    logic [11:0] pin_meta_reg;
    logic [11:0] pin_sync_reg;
    logic [5:0] disc_prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 12'h000;
            pin_sync_reg <= 12'h000;
            disc_prev_reg <= 6'h00;
        end else begin
            pin_meta_reg <= {div32_in, div64_in, div128_in, clk_200m_in,
                             clk_100m_in, ref_10m_in, disc_in};
            pin_sync_reg <= pin_meta_reg;
            disc_prev_reg <= pin_sync_reg[5:0];
        end
    end

    wire logic [5:0] mon = pin_sync_reg[5:0];   // [R04] [R05]
    // Reset to the pulled-up idle level, so no false halt after reset
    logic halt_meta_reg;
    logic halt_sync_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_meta_reg <= 1'b1;
            halt_sync_reg <= 1'b1;
        end else begin
            halt_meta_reg <= halt_line_in;
            halt_sync_reg <= halt_meta_reg;
        end
    end

    wire logic halt_level = halt_sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_reg;
    logic [11:0] edge_reg;
    logic [15:0] sel_reg;
    logic [31:0] range_reg;
    logic [31:0] holdoff_reg;
    logic [31:0] evt_cnt_reg [6];
    logic [11:0] sweep_cnt_reg;
    logic [31:0] timer_reg;
    logic [31:0] st_cnt_reg;
    logic [1:0] begin_cnt_reg;
    logic acq_on_reg;
    sweep_state_t state_reg;
    sweep_state_t state_next;
    logic [31:0] st_cnt_next;

    ////////////////////////////////////////////////////////////////////////
    // Edge selection and per-channel counting
    logic [5:0] evt;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            evt[i] = (edge_reg[2*i] & mon[i] & ~disc_prev_reg[i])
                   | (edge_reg[2*i+1] & ~mon[i] & disc_prev_reg[i]); // [R01]
        end
    end

    // Counters never stall, so a burst cannot overflow a queue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 6; i++) begin
                evt_cnt_reg[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (evt[i]) begin
                    evt_cnt_reg[i] <= evt_cnt_reg[i] + 32'h0000_0001; // [R02] [R03]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sweep engine
    wire logic arm = ctrl_reg[`CTRL_ARM];
    wire logic halt = ctrl_reg[`CTRL_HALT_WATCH] & ~halt_level;
    wire logic trig = evt[0];
    wire logic start_sweep = (state_reg == ST_ARMED) & arm & trig & ~halt;

    always_comb begin
        state_next = state_reg;
        st_cnt_next = st_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (arm) begin
                    state_next = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!arm) begin
                    state_next = ST_IDLE;
                end else if (trig) begin
                    state_next = ST_WINDOW;             // [R16]
                    st_cnt_next = range_reg;
                end
            end
            ST_WINDOW: begin
                if (st_cnt_reg == 32'h0000_0000) begin
                    state_next = ST_DEAD;               // [R17]
                    st_cnt_next = DEAD_CYC - 32'h0000_0001;
                end else begin
                    st_cnt_next = st_cnt_reg - 32'h0000_0001;
                end
            end
            ST_DEAD: begin
                if (st_cnt_reg != 32'h0000_0000) begin
                    st_cnt_next = st_cnt_reg - 32'h0000_0001;
                end else if (holdoff_reg != 32'h0000_0000) begin
                    state_next = ST_HOLDOFF;
                    st_cnt_next = holdoff_reg - 32'h0000_0001;
                end else begin
                    state_next = arm ? ST_ARMED : ST_IDLE;
                end
            end
            ST_HOLDOFF: begin
                if (st_cnt_reg != 32'h0000_0000) begin
                    st_cnt_next = st_cnt_reg - 32'h0000_0001;
                end else begin
                    state_next = arm ? ST_ARMED : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (halt) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            st_cnt_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            st_cnt_reg <= st_cnt_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sweep_cnt_reg <= 12'h000;
            begin_cnt_reg <= 2'h0;
            timer_reg <= 32'h0000_0000;
            acq_on_reg <= 1'b0;
        end else begin
            acq_on_reg <= ctrl_reg[`CTRL_ACQ] & (state_next != ST_IDLE);
            if (start_sweep) begin
                sweep_cnt_reg <= sweep_cnt_reg + 12'h001;   // [R13]
                begin_cnt_reg <= BEGIN_CYC;                 // [R10]
            end else if (begin_cnt_reg != 2'h0) begin
                begin_cnt_reg <= begin_cnt_reg - 2'h1;
            end
            if (acq_on_reg) begin
                timer_reg <= timer_reg + 32'h0000_0001;     // [R11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source vector and the two outputs
    wire logic st_armed = state_reg == ST_ARMED;
    wire logic st_window = state_reg == ST_WINDOW;
    wire logic st_hold = state_reg == ST_HOLDOFF;
    wire logic end_sweep_dead = st_hold | (state_reg == ST_DEAD);
    wire logic sweep_begin_pulse = begin_cnt_reg != 2'h0;
    wire logic [`SRC_COUNT-1:0] src = {
        sweep_cnt_reg,                                        // [R12]
        timer_reg,                                            // [R11]
        end_sweep_dead, st_hold, st_window, acq_on_reg, st_armed, // [R09]
        sweep_begin_pulse, halt_level,                        // [R10] [R09]
        mon,                                                  // [R08]
        pin_sync_reg[11], pin_sync_reg[8], pin_sync_reg[10],  // [R07] [R06]
        pin_sync_reg[7], pin_sync_reg[9], pin_sync_reg[6],
        1'b0};                                                // [R06]

    sync_source_mux u_fast (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(src),
        .sel(sel_reg[`SEL1_LSB +: 7]),
        .invert(sel_reg[`INV1_BIT]),
        .nim_level_n_reg(fast_sync_n),
        .ttl_level_reg()
    );

    sync_source_mux u_ttl (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(src),
        .sel(sel_reg[`SEL2_LSB +: 7]),
        .invert(sel_reg[`INV2_BIT]),
        .nim_level_n_reg(),
        .ttl_level_reg(ttl_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; one write and one read in flight
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take = s_axi_wvalid & s_axi_wready;
    wire logic do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire logic aw_held_next = (aw_held_reg | aw_take) & ~do_write;
    wire logic w_held_next = (w_held_reg | w_take) & ~do_write;
    wire logic wr_hit = awaddr_reg <= `OFF_HOLDOFF;
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
    wire logic [7:0] ra = s_axi_araddr[7:0];
    wire logic rd_count = ra >= `OFF_COUNT0 && ra <= `OFF_COUNT5;
    wire logic rd_hit = (s_axi_araddr[31:8] == 24'h000000)
        && (ra[1:0] == 2'h0) && (ra <= `OFF_STATUS || rd_count);
    wire logic [2:0] rd_ch = 3'(ra[4:2]);
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (ra)
            `OFF_CTRL: rd_val = ctrl_reg;
            `OFF_EDGE: rd_val = {20'h00000, edge_reg};
            `OFF_SEL: rd_val = {16'h0000, sel_reg};
            `OFF_RANGE: rd_val = range_reg;
            `OFF_HOLDOFF: rd_val = holdoff_reg;
            `OFF_STATUS: begin
                rd_val[2:0] = state_reg;
                rd_val[`STAT_HALT_BIT] = halt_level;
                rd_val[`STAT_SWEEP_LSB +: 12] = sweep_cnt_reg;
            end
            default: rd_val = rd_count ? evt_cnt_reg[rd_ch] : 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            s_axi_awready <= ~aw_held_next;
            s_axi_wready <= ~w_held_next;
            if (aw_take) begin
                awaddr_reg <= (s_axi_awaddr[31:8] == 24'h000000 &&
                    s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[7:0] : 8'hFF;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RESET;
            edge_reg <= `EDGE_RESET;
            sel_reg <= `SEL_RESET;
            range_reg <= `RANGE_RESET;
            holdoff_reg <= `HOLDOFF_RESET;
        end else if (do_write) begin
            case (awaddr_reg)
                `OFF_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
                `OFF_EDGE: edge_reg <= 12'(merge({20'h00000, edge_reg},
                                                 wdata_reg, wstrb_reg));
                `OFF_SEL: sel_reg <= 16'(merge({16'h0000, sel_reg},
                                               wdata_reg, wstrb_reg)); // [R18]
                `OFF_RANGE: range_reg <= merge(range_reg, wdata_reg, wstrb_reg);
                `OFF_HOLDOFF: holdoff_reg <= merge(holdoff_reg, wdata_reg,
                                                   wstrb_reg);
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_rvalid <= rvalid_next;
            s_axi_arready <= ~rvalid_next & ~ar_take;
            if (ar_take) begin
                s_axi_rdata <= rd_hit ? rd_val : 32'h0000_0000;
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_rise;
        (edge_reg[1:0] == 2'h1 && mon[0] && !disc_prev_reg[0])
            |=> evt_cnt_reg[0] == $past(evt_cnt_reg[0]) + 32'h0000_0001;
    endproperty
    a_edge_rise: assert property (p_edge_rise) // [R01]
        else $error("rising edge not counted");
    property p_sweep_inc;
        start_sweep |=> sweep_cnt_reg == $past(sweep_cnt_reg) + 12'h001;
    endproperty
    a_sweep_inc: assert property (p_sweep_inc) // [R13]
        else $error("sweep counter did not advance");
    property p_begin_len;
        start_sweep |=> sweep_begin_pulse [*2] ##1 !sweep_begin_pulse;
    endproperty
    a_begin_len: assert property (p_begin_len) // [R10]
        else $error("sweep begin pulse not two cycles");
    property p_start;
        start_sweep |=> state_reg == ST_WINDOW && st_cnt_reg == $past(range_reg);
    endproperty
    a_start: assert property (p_start) // [R16]
        else $error("trigger did not start sweep");
    property p_dead_entry;
        (st_window && st_cnt_reg == 32'h0000_0000 && !halt)
            |=> state_reg == ST_DEAD && st_cnt_reg == DEAD_CYC - 32'h1;
    endproperty
    a_dead_entry: assert property (p_dead_entry) // [R17]
        else $error("dead time not entered with full count");
    property p_no_trig_dead;
        end_sweep_dead |=> state_reg != ST_WINDOW;
    endproperty
    a_no_trig_dead: assert property (p_no_trig_dead) // [R17]
        else $error("sweep started during dead time");
    property p_timer_hold;
        !acq_on_reg |=> $stable(timer_reg);
    endproperty
    a_timer_hold: assert property (p_timer_hold) // [R11]
        else $error("timer ran while not sampling");
    property p_fast_level;
        sel_reg[6:0] == 7'h0F && !sel_reg[`INV1_BIT] && $stable(sel_reg)
            |=> fast_sync_n == !$past(st_armed);
    endproperty
    a_fast_level: assert property (p_fast_level) // [R15] [R14]
        else $error("fast output polarity wrong");
    property p_unused_zero;
        sel_reg[14:8] >= 7'h40 && !sel_reg[`INV2_BIT] && $stable(sel_reg)
            |=> !ttl_sync;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // [R18]
        else $error("unused code not static zero");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read data dropped before taken");
    c_sweep: cover property (start_sweep ##[1:300] end_sweep_dead);
    c_holdoff: cover property (st_hold ##1 st_armed);
    c_halt: cover property (halt && st_window);
endmodule : sync_output_selector

// ---- testbench/far_side_model.sv ----
// Far-side lab equipment: discriminator levels, halt line, clock pins
`timescale 1ns/1ps
module far_side_model (
    input wire logic halt_req,
    output logic [5:0] disc_in,
    output logic halt_line_in,
    output logic ref_10m_in,
    output logic clk_100m_in,
    output logic clk_200m_in,
    output logic div128_in,
    output logic div64_in,
    output logic div32_in
);
    // Wired line with pull-up: high unless someone pulls it down
    assign halt_line_in = halt_req ? 1'b0 : 1'b1;
    initial disc_in = 6'h00;
    initial begin
        ref_10m_in = 1'b0;
        forever #50 ref_10m_in = ~ref_10m_in;
    end
    initial begin
        clk_100m_in = 1'b0;
        forever #5 clk_100m_in = ~clk_100m_in;
    end
    initial begin
        clk_200m_in = 1'b0;
        forever #2.5 clk_200m_in = ~clk_200m_in;
    end
    initial begin
        div128_in = 1'b0;
        forever #6.4 div128_in = ~div128_in;
    end
    initial begin
        div64_in = 1'b0;
        forever #3.2 div64_in = ~div64_in;
    end
    initial begin
        div32_in = 1'b0;
        forever #1.6 div32_in = ~div32_in;
    end
    ////////////////////////////////////////////////////////////////////////
    // Pulse off the bench clock phase, so edges land between samples
    task pulse(input logic [5:0] m, input int ns);
        #1.3;
        disc_in = disc_in | m;
        #(ns);
        disc_in = disc_in & ~m;
        #20;
    endtask : pulse
endmodule : far_side_model

// ---- testbench/sync_output_selector_tb.sv ----
// Self-checking bench for the sync output selector
`timescale 1ns/1ps
module sync_output_selector_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, halt_req = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, fast_sync_n, ttl_sync, halt_line_in;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] disc_in;
    logic ref_10m_in, clk_100m_in, clk_200m_in;
    logic div128_in, div64_in, div32_in;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    typedef struct packed {logic [15:0] sel; logic ttl; logic fast_n;} row_t;
    row_t rows [9] = '{
        '{16'h0000, 1'b0, 1'b1},
        '{16'h8080, 1'b1, 1'b0},
        '{16'h0D8D, 1'b1, 1'b1},
        '{16'h0F0F, 1'b1, 1'b0},
        '{16'h1010, 1'b1, 1'b0},
        '{16'h3636, 1'b1, 1'b0},
        '{16'h3434, 1'b0, 1'b1},
        '{16'h4040, 1'b0, 1'b1},
        '{16'h0707, 1'b0, 1'b1}
    };
    logic [31:0] rst_val [5] = '{32'h0, 32'h555, 32'h0, 32'hFF, 32'h0};
    logic [6:0] sw_code [4] = '{7'h0E, 7'h11, 7'h12, 7'h13};
    int sw_len [4] = '{2, 4, 2, 26};

    sync_output_selector dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .disc_in, .halt_line_in,
        .ref_10m_in, .clk_100m_in, .clk_200m_in, .div128_in, .div64_in,
        .div32_in, .fast_sync_n, .ttl_sync
    );
    far_side_model far_u (
        .halt_req, .disc_in, .halt_line_in, .ref_10m_in, .clk_100m_in,
        .clk_200m_in, .div128_in, .div64_in, .div32_in
    );
    ////////////////////////////////////////////////////////////////////////
    initial forever #2 aclk = ~aclk;
    // Whole run is a few hundred cycles; far below this ceiling
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task conclude;
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////////////
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // Length of the next high pulse on the TTL output, in cycles
    task width(output int n);
        n = 0;
        do @(posedge aclk); while (ttl_sync !== 1'b0);
        do @(posedge aclk); while (ttl_sync !== 1'b1);
        do begin
            n++;
            @(posedge aclk);
        end while (ttl_sync === 1'b1);
    endtask : width
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int w;
        repeat (2) @(posedge aclk);
        chk("in_reset", {s_axi_awready, s_axi_bvalid, fast_sync_n, ttl_sync},
            4'b0010);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(4 * i, d, r);
            chk("reset_value", d, rst_val[i]);
        end
        rd(32'h18, d, r);
        chk("unmapped", {d[29:0], r}, 32'h2);
        wr(32'h14, 32'h1, 2'h2);
        wr(32'h0C, 32'h3, 2'h0);
        wr(32'h10, 32'h2, 2'h0);
        wr(32'h00, 32'h1, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(32'h08, {17'h0, sw_code[i], 8'h00}, 2'h0);
            repeat (40) @(posedge aclk);
            fork
                far_u.pulse(6'h01, 12);
                width(w);
            join
            chk("sweep_width", w, sw_len[i]);
        end
        rd(32'h14, d, r);
        chk("sweep_count", {d[27:16], d[3:0]}, 16'h0049);
        rd(32'h20, d, r);
        chk("trigger_edges", d, 32'h4);
        wr(32'h04, 32'h56D, 2'h0);
        far_u.pulse(6'h06, 12);
        far_u.pulse(6'h06, 12);
        repeat (5) @(posedge aclk);
        rd(32'h24, d, r);
        chk("both_edges", d, 32'h4);
        rd(32'h28, d, r);
        chk("falling_edges", d, 32'h2);
        wr(32'h08, 32'h0800, 2'h0);
        for (int i = 0; i < 2; i++) begin
            fork
                far_u.pulse(6'h02, 3 + 9 * i);
                width(w);
            join
            chk("monitor_width", w, 1 + 2 * i);
        end
        wr(32'h00, 32'h3, 2'h0);
        wr(32'h08, 32'h1515, 2'h0);
        width(w);
        chk("tap1_high", w, 2);
        for (int i = 0; i < 9; i++) begin
            wr(32'h08, {16'h0, rows[i].sel}, 2'h0);
            repeat (4) @(posedge aclk);
            chk("outputs", {ttl_sync, fast_sync_n},
                {rows[i].ttl, rows[i].fast_n});
        end
        wr(32'h00, 32'h7, 2'h0);
        halt_req <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(32'h14, d, r);
        chk("halted", d[3:0], 4'h0);
        halt_req <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(32'h14, d, r);
        chk("rearmed", d[3:0], 4'h9);
        conclude();
    end
endmodule : sync_output_selector_tb
